// ===== gpte_defines.vh
// Constants for the global page table entry decode block.
`ifndef GPTE_DEFINES_VH
`define GPTE_DEFINES_VH
// Page size in bytes and the offset width within a page.
`define GPTE_PAGE_BYTES 4096
`define GPTE_OFS_W 12
// Number of entries held in the table and the width of an index.
`define GPTE_ENTRIES 1024
`define GPTE_IDX_W 10
// Graphics address width covered by the table.
`define GPTE_GADDR_W 22
// Aperture byte address width, one aligned dword per entry.
`define GPTE_APT_W 12
// Entry field positions.
`define GPTE_PAGE_HI 31
`define GPTE_PAGE_LO 12
`define GPTE_EXT_HI 11
`define GPTE_EXT_LO 4
`define GPTE_DTYPE_BIT 3
`define GPTE_LLC_BIT 2
`define GPTE_L3_BIT 1
`define GPTE_VALID_BIT 0
// Reset values of the output registers.
`define GPTE_RST_WORD 32'h00000000
`define GPTE_RST_PADDR 40'h0000000000
`endif

// ===== gpte_table_ram.v
// Entry storage with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
`include "gpte_defines.vh"

module gpte_table_ram (
  input wire i_clk,
  input wire i_we,
  input wire [`GPTE_IDX_W-1:0] i_waddr,
  input wire [31:0] i_wdata,
  input wire [`GPTE_IDX_W-1:0] i_raddr_a,
  output reg [31:0] o_rdata_a,
  input wire [`GPTE_IDX_W-1:0] i_raddr_b,
  output reg [31:0] o_rdata_b
);

  // The entry array, one 32-bit word per graphics page.
  reg [31:0] mem [0:`GPTE_ENTRIES-1];

  // Writes land at the edge; reads in the same cycle see the old word.
  always @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end

endmodule
`default_nettype wire

// ===== gpte_decode.v
// Global page table: host aperture access and graphics address translation.
`timescale 1ns/1ps
`default_nettype none
`include "gpte_defines.vh"
// Both ports are two-stage pipelines. A request taken at one edge is
// answered two edges later, and another may follow in every cycle.
// Reset clears the pipelines but not the table; every entry must be
// written through the aperture before a client looks it up.

module gpte_decode (
  input wire i_clk,
  input wire i_reset,
  // Host aperture port.
  input wire i_apt_req,
  input wire i_apt_we,
  input wire [`GPTE_APT_W-1:0] i_apt_addr,
  input wire [31:0] i_apt_wdata,
  output reg o_apt_ack,
  output reg o_apt_misaligned,
  output reg [31:0] o_apt_rdata,
  // Graphics client translation port.
  input wire i_xl_req,
  input wire i_xl_write,
  input wire i_xl_cpu_read,
  input wire i_xl_state_dtype,
  input wire [`GPTE_GADDR_W-1:0] i_xl_gaddr,
  output reg o_xl_valid,
  output reg [39:0] o_xl_paddr,
  output reg o_xl_mapped,
  output reg o_xl_dtype,
  output reg o_xl_llc_alloc,
  output reg o_xl_l3_alloc,
  output reg o_xl_l3_coherent,
  output reg o_xl_fault
);

  // Page index of a graphics address; the low bits are the page offset.
  function [`GPTE_IDX_W-1:0] page_index;
    input [`GPTE_GADDR_W-1:0] gaddr;
    begin
      page_index = gaddr[`GPTE_GADDR_W-1:`GPTE_OFS_W];
    end
  endfunction

  // Entry index of an aperture byte address, one dword per entry.
  function [`GPTE_IDX_W-1:0] apt_index;
    input [`GPTE_APT_W-1:0] addr;
    begin
      apt_index = addr[`GPTE_APT_W-1:2];
    end
  endfunction

  // Only dword-aligned aperture accesses are honoured.
  wire apt_aligned;
  // Write strobe into the table.
  wire tbl_we;
  // Registered table words for the aperture and the translation ports.
  wire [31:0] apt_word;
  wire [31:0] xl_word;

  // Aperture request held for the cycle of the table read.
  reg apt_pend_q;
  // The pending access is a read; it returns data unless it is misaligned.
  reg apt_rd_q;
  // The pending access was misaligned and is refused.
  reg apt_bad_q;
  // Translation request held for the cycle of the table read.
  reg xl_pend_q;
  // The pending lookup is a write.
  reg xl_write_q;
  // The pending lookup is a CPU read, which never faults.
  reg xl_cpu_rd_q;
  // Data-type flag from state for the pending lookup.
  reg xl_state_dt_q;
  // Page offset carried beside the table read.
  reg [`GPTE_OFS_W-1:0] xl_ofs_q;

  assign apt_aligned = (i_apt_addr[1:0] == 2'h0);
  // A misaligned write is dropped so it cannot corrupt a neighbour entry.
  assign tbl_we = i_apt_req & i_apt_we & apt_aligned;

  // The aperture aliases the live entries; translation reads them too.
  gpte_table_ram u_table (
    .i_clk(i_clk),
    .i_we(tbl_we),
    .i_waddr(apt_index(i_apt_addr)),
    .i_wdata(i_apt_wdata),
    .i_raddr_a(apt_index(i_apt_addr)),
    .o_rdata_a(apt_word),
    .i_raddr_b(page_index(i_xl_gaddr)),
    .o_rdata_b(xl_word)
  );

  // Stage one captures the request attributes beside the table read.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      // Nothing pending after reset.
      apt_pend_q <= 1'b0;
      apt_rd_q <= 1'b0;
      apt_bad_q <= 1'b0;
      xl_pend_q <= 1'b0;
      xl_write_q <= 1'b0;
      xl_cpu_rd_q <= 1'b0;
      xl_state_dt_q <= 1'b0;
      xl_ofs_q <= {`GPTE_OFS_W{1'b0}};
    end
    else
    begin
      // Aperture request attributes.
      apt_pend_q <= i_apt_req;
      apt_rd_q <= i_apt_req & ~i_apt_we;
      apt_bad_q <= i_apt_req & ~apt_aligned;
      // Translation request attributes.
      xl_pend_q <= i_xl_req;
      xl_write_q <= i_xl_write;
      // A write is never counted as a CPU read.
      xl_cpu_rd_q <= i_xl_cpu_read & ~i_xl_write;
      xl_state_dt_q <= i_xl_state_dtype;
      // The page offset passes straight through to the result.
      xl_ofs_q <= i_xl_gaddr[`GPTE_OFS_W-1:0];
    end
  end

  // Stage two answers the aperture access.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      // Quiet port after reset.
      o_apt_ack <= 1'b0;
      o_apt_misaligned <= 1'b0;
      o_apt_rdata <= `GPTE_RST_WORD;
    end
    else
    begin
      // Every request is acknowledged, refused ones included.
      o_apt_ack <= apt_pend_q;
      // Misaligned accesses are flagged beside their ack.
      o_apt_misaligned <= apt_bad_q;
      if (apt_rd_q & ~apt_bad_q)
      begin
        // Aligned read returns the live entry.
        o_apt_rdata <= apt_word;
      end
      else
      begin
        // Writes and refused reads return zero.
        o_apt_rdata <= `GPTE_RST_WORD;
      end
    end
  end

  // Stage two decodes the entry into the translation result.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      // No result after reset.
      o_xl_valid <= 1'b0;
      o_xl_paddr <= `GPTE_RST_PADDR;
      o_xl_mapped <= 1'b0;
      o_xl_dtype <= 1'b0;
      o_xl_llc_alloc <= 1'b0;
      o_xl_l3_alloc <= 1'b0;
      o_xl_l3_coherent <= 1'b0;
      o_xl_fault <= 1'b0;
    end
    else
    begin
      // Result strobe and valid-bit report for the pending lookup.
      o_xl_valid <= xl_pend_q;
      o_xl_mapped <= xl_pend_q & xl_word[`GPTE_VALID_BIT];
      // Cache steering follows the entry bits directly.
      o_xl_llc_alloc <= xl_pend_q & xl_word[`GPTE_LLC_BIT];
      o_xl_l3_alloc <= xl_pend_q & xl_word[`GPTE_L3_BIT];
      // Coherence with L3 is kept whatever the allocation bit says.
      o_xl_l3_coherent <= xl_pend_q;
      if (xl_pend_q & xl_write_q)
      begin
        // Writes use the OR of entry flag and state flag.
        o_xl_dtype <= xl_word[`GPTE_DTYPE_BIT] | xl_state_dt_q;
      end
      else
      begin
        // Reads never see the data-type flag.
        o_xl_dtype <= 1'b0;
      end
      if (xl_pend_q & xl_word[`GPTE_VALID_BIT])
      begin
        // Extension byte, page number, then the page offset.
        o_xl_paddr <= {xl_word[`GPTE_EXT_HI:`GPTE_EXT_LO],
                       xl_word[`GPTE_PAGE_HI:`GPTE_PAGE_LO],
                       xl_ofs_q};
        // A valid entry never raises the page table error.
        o_xl_fault <= 1'b0;
      end
      else
      begin
        // Address fields of an invalid entry are never used.
        o_xl_paddr <= `GPTE_RST_PADDR;
        // CPU reads through an invalid entry stay silent.
        o_xl_fault <= xl_pend_q & ~xl_cpu_rd_q;
      end
    end
  end

endmodule
`default_nettype wire

// ===== gpte_decode_assertions.sv
// Checker for the aperture and translation timing of the entry decode block.
`timescale 1ns/1ps
`default_nettype none
module gpte_decode_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_apt_req,
  input wire logic [11:0] i_apt_addr,
  input wire logic i_xl_req,
  input wire logic i_xl_write,
  input wire logic i_xl_cpu_read,
  input wire logic [21:0] i_xl_gaddr,
  input wire logic o_apt_ack,
  input wire logic o_apt_misaligned,
  input wire logic o_xl_valid,
  input wire logic [39:0] o_xl_paddr,
  input wire logic o_xl_mapped,
  input wire logic o_xl_dtype,
  input wire logic o_xl_l3_coherent,
  input wire logic o_xl_fault
);
  // All checks share the one clock and its reset.
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // An answer comes back two edges after its request was taken.
  sequence s_answer(sig);
    ##2 sig;
  endsequence
  a_ack_two_cycles: assert property (i_apt_req |-> s_answer(o_apt_ack)) else $error("late ack");
  a_ack_has_cause: assert property (o_apt_ack |-> $past(i_apt_req, 2)) else $error("stray ack");
  a_misaligned_flag: assert property ((i_apt_req && i_apt_addr[1:0] != 2'h0) |->
    s_answer(o_apt_misaligned)) else $error("misaligned access not flagged");
  a_xl_two_cycles: assert property (i_xl_req |-> s_answer(o_xl_valid)) else $error("late xl");
  a_fault_cause: assert property (o_xl_valid |-> o_xl_fault == (!o_xl_mapped &&
    ($past(i_xl_write, 2) || !$past(i_xl_cpu_read, 2)))) else $error("wrong fault");
  a_coherent_always: assert property (o_xl_valid |-> o_xl_l3_coherent) else $error("coh");
  a_page_offset: assert property ((o_xl_valid && o_xl_mapped) |->
    o_xl_paddr[11:0] == $past(i_xl_gaddr[11:0], 2)) else $error("offset lost");
  a_unmapped_zero: assert property ((o_xl_valid && !o_xl_mapped) |-> o_xl_paddr == 40'h0)
    else $error("invalid entry used");
  a_read_dtype_off: assert property ((o_xl_valid && !$past(i_xl_write, 2)) |-> !o_xl_dtype)
    else $error("flag set on read");
  a_flag_with_ack: assert property (o_apt_misaligned |-> o_apt_ack)
    else $error("flag without ack");
  a_idle_outputs_zero: assert property (!o_xl_valid |-> (o_xl_paddr == 40'h0 &&
    !o_xl_mapped && !o_xl_dtype && !o_xl_l3_coherent && !o_xl_fault))
    else $error("result without strobe");
endmodule
bind gpte_decode gpte_decode_checker chk_u (.*);
`default_nettype wire

// ===== gpte_agent_model.sv
// Host and graphics client model that drives the request ports of the block.
`timescale 1ns/1ps
`default_nettype none
module gpte_agent_model (
  input wire logic i_clk,
  output logic i_apt_req,
  output logic i_apt_we,
  output logic [11:0] i_apt_addr,
  output logic [31:0] i_apt_wdata,
  output logic i_xl_req,
  output logic i_xl_write,
  output logic i_xl_cpu_read,
  output logic i_xl_state_dtype,
  output logic [21:0] i_xl_gaddr,
  input wire logic o_apt_ack,
  input wire logic o_apt_misaligned,
  input wire logic [31:0] o_apt_rdata,
  input wire logic o_xl_valid,
  input wire logic [39:0] o_xl_paddr,
  input wire logic o_xl_mapped,
  input wire logic o_xl_dtype,
  input wire logic o_xl_llc_alloc,
  input wire logic o_xl_l3_alloc,
  input wire logic o_xl_l3_coherent,
  input wire logic o_xl_fault
);
  // Requests stay idle from time zero.
  initial
  begin
    {i_apt_req, i_apt_we, i_xl_req, i_xl_write, i_xl_cpu_read, i_xl_state_dtype} = 6'h00;
    {i_apt_addr, i_apt_wdata, i_xl_gaddr} = 66'h0;
  end
  // One whole dword per access; the answer is taken when the ack shows.
  task automatic apt(input logic we, input logic [11:0] a, input logic [31:0] d,
    output logic [45:0] r, output logic to);
    int n;
    @(posedge i_clk) #1;
    {i_apt_req, i_apt_we, i_apt_addr, i_apt_wdata} = {1'b1, we, a, d};
    @(posedge i_clk) #1;
    i_apt_req = 1'b0;
    i_apt_wdata = ~d;
    for (n = 0; n < 4 && o_apt_ack !== 1'b1; n++) @(posedge i_clk) #1;
    r = {13'h0000, o_apt_misaligned, o_apt_rdata};
    to = (o_apt_ack !== 1'b1);
  endtask
  // One lookup; k holds write, CPU read and state flag in that order.
  task automatic xl(input logic [2:0] k, input logic [21:0] g, output logic [45:0] r,
    output logic to);
    int n;
    @(posedge i_clk) #1;
    {i_xl_req, i_xl_write, i_xl_cpu_read, i_xl_state_dtype, i_xl_gaddr} = {1'b1, k, g};
    @(posedge i_clk) #1;
    i_xl_req = 1'b0;
    for (n = 0; n < 4 && o_xl_valid !== 1'b1; n++) @(posedge i_clk) #1;
    r = {o_xl_paddr, o_xl_mapped, o_xl_dtype, o_xl_llc_alloc, o_xl_l3_alloc, o_xl_l3_coherent,
      o_xl_fault};
    to = (o_xl_valid !== 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== tb_gpte_decode.sv
// Self-checking bench for the global page table entry decode block.
`timescale 1ns/1ps
`default_nettype none
module tb_gpte_decode;
  logic i_clk, i_reset, i_apt_req, i_apt_we, o_apt_ack, o_apt_misaligned, i_xl_req, i_xl_write;
  logic i_xl_cpu_read, i_xl_state_dtype, o_xl_valid, o_xl_mapped, o_xl_dtype, o_xl_llc_alloc;
  logic o_xl_l3_alloc, o_xl_l3_coherent, o_xl_fault, to;
  logic [11:0] i_apt_addr;
  logic [31:0] i_apt_wdata, o_apt_rdata;
  logic [21:0] i_xl_gaddr;
  logic [39:0] o_xl_paddr;
  logic [45:0] res;
  int n_mismatch, checks;
  gpte_decode dut_u (.*);
  gpte_agent_model agent_u (.*);
  // Clock of 50 ns period.
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Mismatches %0d of %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Compares one answer; a lost answer also ends the run.
  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    checks++;
    if (got !== exp || to)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      if (to)
        complete_run();
    end
  endtask
  // Aperture writes and reads, including refused misaligned ones.
  task automatic s_aperture;
    agent_u.apt(1'b1, 12'h00C, 32'h12345A5F, res, to);
    chk(res, 46'h0);
    agent_u.apt(1'b1, 12'h00E, 32'hFFFFFFFF, res, to);
    chk(res, 46'h100000000);
    agent_u.apt(1'b0, 12'h00C, 32'h0, res, to);
    chk(res, 46'h12345A5F);
    agent_u.apt(1'b1, 12'hFFC, 32'h00001002, res, to);
    chk(res, 46'h0);
    agent_u.apt(1'b0, 12'hFFD, 32'h0, res, to);
    chk(res, 46'h100000000);
    agent_u.apt(1'b0, 12'hFFC, 32'h0, res, to);
    chk(res, 46'h00001002);
    agent_u.apt(1'b1, 12'h024, 32'h00000001, res, to);
    chk(res, 46'h0);
  endtask
  // Lookups through valid and invalid entries.
  task automatic s_translate;
    agent_u.xl(3'h4, 22'h003ABC, res, to);
    chk(res, {8'hA5, 20'h12345, 12'hABC, 6'h3E});
    agent_u.xl(3'h0, 22'h003ABC, res, to);
    chk(res, {8'hA5, 20'h12345, 12'hABC, 6'h2E});
    agent_u.xl(3'h6, 22'h3FF010, res, to);
    chk(res, 46'h07);
    agent_u.xl(3'h2, 22'h3FF010, res, to);
    chk(res, 46'h06);
    agent_u.xl(3'h1, 22'h3FF010, res, to);
    chk(res, 46'h07);
    agent_u.xl(3'h5, 22'h009FFF, res, to);
    chk(res, {40'h0000000FFF, 6'h32});
  endtask
  // Reset in mid-run: outputs quiet after release, table contents kept.
  task automatic s_reset;
    to = 1'b0;
    @(posedge i_clk) #1;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    @(posedge i_clk) #1;
    res = {11'h000, o_xl_valid, o_apt_ack, o_apt_misaligned, o_apt_rdata};
    chk(res, 46'h0);
    res = {o_xl_paddr, o_xl_mapped, o_xl_dtype, o_xl_llc_alloc, o_xl_l3_alloc,
      o_xl_l3_coherent, o_xl_fault};
    chk(res, 46'h0);
    agent_u.apt(1'b0, 12'h00C, 32'h0, res, to);
    chk(res, 46'h12345A5F);
  endtask
  // Reset for 20 cycles, then run the scenarios.
  initial
  begin
    i_reset = 1'b1;
    n_mismatch = 0;
    checks = 0;
    repeat (20) @(posedge i_clk);
    #1 i_reset = 1'b0;
    s_aperture();
    s_translate();
    s_reset();
    complete_run();
  end
endmodule
`default_nettype wire
